// ===== design/vwp_link.sv
// Serial-clock side: shifts bits, answers acknowledge and sends read data.
`timescale 1ns/1ns
`default_nettype none
module vwp_link
	import vwp_pkg::*;
#(
	parameter logic [6:0] ADDR = SLAVE_ADDR
) (
	// Serial clock from the master and sampled data line.
	input  wire logic scl,
	input  wire logic rst,
	input  wire logic sda_in,
	// Toward the system-clock side.
	vwp_link_if.link  lk
);
	vwp_phase_e  phase_r;
	logic [3:0]  cnt_r;
	logic [7:0]  shift_r;
	logic [6:0]  wr_code_r;
	logic        wr_tgl_r;
	logic        sda_oe_r;

	// Start, stop or supply reset all restart the frame.
	wire         frame_arst = lk.link_rst;
	wire         addr_hit   = (shift_r[7:1] == ADDR);
	wire         ack_slot   = (cnt_r == BIT_ACK);
	wire [7:0]   rd_byte    = {1'b0, lk.rd_code};
	wire [2:0]   rd_idx     = MSB_IDX - cnt_r[2:0];
	wire         ack_addr   = (phase_r == PH_ADDR) && ack_slot && addr_hit;
	wire         ack_wr     = (phase_r == PH_WDATA) && ack_slot;
	wire         drive_rd   = (phase_r == PH_RDATA) && !ack_slot && !rd_byte[rd_idx];
	wire         sda_oe_nxt = ack_addr || ack_wr || drive_rd;

	// Bits are taken on the rising serial clock; the master makes every edge.
	always_ff @(posedge scl or posedge frame_arst) begin
		if (frame_arst) begin
			cnt_r   <= 4'h0;
			shift_r <= 8'h00;
		end else begin
			cnt_r   <= ack_slot ? 4'h0 : cnt_r + 4'h1;
			shift_r <= ack_slot ? shift_r : {shift_r[6:0], sda_in};
		end
	end

	always_ff @(posedge scl or posedge frame_arst) begin
		if (frame_arst) begin
			phase_r <= PH_ADDR;
		end else if (ack_slot) begin
			case (phase_r)
				PH_ADDR:  phase_r <= !addr_hit ? PH_IGNORE :
					(shift_r[RW_POS] ? PH_RDATA : PH_WDATA);
				PH_WDATA: phase_r <= PH_WDATA;
				PH_RDATA: phase_r <= sda_in ? PH_IGNORE : PH_RDATA;
				default:  phase_r <= PH_IGNORE;
			endcase
		end
	end

	// Write results survive the frame restart, so only the supply reset clears them.
	always_ff @(posedge scl or posedge rst) begin
		if (rst) begin
			wr_code_r <= WIPER_RESET;
			wr_tgl_r  <= 1'b0;
		end else if (ack_wr) begin
			wr_code_r <= shift_r[6:0];
			wr_tgl_r  <= ~wr_tgl_r;
		end
	end

	// The line is only pulled low or released, changed while the clock is low.
	always_ff @(negedge scl or posedge frame_arst) begin
		if (frame_arst) begin
			sda_oe_r <= 1'b0;
		end else begin
			sda_oe_r <= sda_oe_nxt;
		end
	end

	assign lk.wr_code = wr_code_r;
	assign lk.wr_tgl  = wr_tgl_r;
	assign lk.sda_oe  = sda_oe_r;
endmodule : vwp_link
`default_nettype wire

// ===== design/vwp_link_if.sv
// Carrier between the system-clock side and the serial-clock side.
`timescale 1ns/1ns
`default_nettype none
interface vwp_link_if;
	logic       link_rst;
	logic [6:0] rd_code;
	logic [6:0] wr_code;
	logic       wr_tgl;
	logic       sda_oe;

	modport sys (
		output link_rst,
		output rd_code,
		input  wr_code,
		input  wr_tgl,
		input  sda_oe
	);

	modport link (
		input  link_rst,
		input  rd_code,
		output wr_code,
		output wr_tgl,
		output sda_oe
	);
endinterface : vwp_link_if
`default_nettype wire

// ===== design/vwp_pkg.sv
// Constants and types shared by the volatile wiper block.
package vwp_pkg;

	localparam int          WIPER_W     = 7;
	localparam int          TAP_COUNT   = 128;
	localparam logic [6:0]  WIPER_RESET = 7'h3f;
	localparam logic [6:0]  ZERO_CODE   = 7'h00;
	localparam logic [6:0]  FULL_CODE   = 7'h7f;
	localparam logic [6:0]  SLAVE_ADDR  = 7'h2f;
	localparam logic [3:0]  BIT_ACK     = 4'h8;
	localparam logic [3:0]  BIT_LAST    = 4'h7;
	localparam logic [2:0]  MSB_IDX     = 3'h7;
	localparam int          RW_POS      = 0;

	typedef enum logic [1:0] {
		PH_ADDR,
		PH_WDATA,
		PH_RDATA,
		PH_IGNORE
	} vwp_phase_e;

endpackage : vwp_pkg

// ===== design/vwp_top.sv
// Volatile wiper setting with supply-reset handling and the two-wire slave port.
`timescale 1ns/1ns
`default_nettype none
module vwp_top
	import vwp_pkg::*;
#(
	parameter logic [6:0] ADDR = SLAVE_ADDR
) (
	// System clock and supply reset (high below the trip level).
	input  wire logic                 clock,
	input  wire logic                 rst,
	// Serial clock pin; its input is also the link clock.
	input  wire logic                 scl,
	output logic                      scl_out,
	output logic                      scl_oe,
	// Serial data pin, open drain.
	input  wire logic                 sda_in,
	output logic                      sda_out,
	output logic                      sda_oe,
	// Wiper state toward the resistor network.
	output logic [WIPER_W-1:0]        wiper_code,
	output logic [TAP_COUNT-1:0]      tap_select,
	output logic                      zero_scale,
	output logic                      full_scale,
	output logic                      static_mode
);
	vwp_link_if lk ();

	logic [1:0]               scl_sync_r;
	logic [1:0]               sda_sync_r;
	logic                     scl_q_r;
	logic                     sda_q_r;
	logic [2:0]               tgl_sync_r;
	logic                     link_rst_r;
	logic [WIPER_W-1:0]       volatile_wiper_setting_r;
	logic [TAP_COUNT-1:0]     tap_select_r;
	logic                     zero_scale_r;
	logic                     full_scale_r;
	logic                     static_mode_r;
	logic                     scl_oe_r;
	logic                     scl_out_r;
	logic                     sda_out_r;

	// The two-flop stage stands in for the glitch filter on the pins.
	wire scl_s      = scl_sync_r[1];
	wire sda_s      = sda_sync_r[1];
	wire start_seen = scl_s && scl_q_r && sda_q_r && !sda_s;
	wire stop_seen  = scl_s && scl_q_r && !sda_q_r && sda_s;
	wire wr_event   = tgl_sync_r[2] ^ tgl_sync_r[1];

	// One compare serves the tap decoder and both end flags, so they cannot disagree.
	function automatic logic code_is(input logic [WIPER_W-1:0] code, input logic [WIPER_W-1:0] tap);
		return code == tap;
	endfunction : code_is

	// Decoded strobes keep the clocked blocks short.
	// Start and Stop both restart the link side.
	wire link_rst_nxt = start_seen || stop_seen;
	wire zero_hit     = code_is(volatile_wiper_setting_r, ZERO_CODE);
	wire full_hit     = code_is(volatile_wiper_setting_r, FULL_CODE);

	// Both pins pass two flops before the edge compare reads them.
	// Pins idle high, so the history resets high and no false edge follows reset.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scl_sync_r <= 2'h3;
		end else begin
			scl_sync_r <= {scl_sync_r[0], scl};
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sda_sync_r <= 2'h3;
		end else begin
			sda_sync_r <= {sda_sync_r[0], sda_in};
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= scl_s;
			sda_q_r <= sda_s;
		end
	end

	// The write toggle crosses on flops; the code beside it has long settled by then.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tgl_sync_r <= 3'h0;
		end else begin
			tgl_sync_r <= {tgl_sync_r[1:0], lk.wr_tgl};
		end
	end

	// Link reset is held for the whole supply fault and pulsed on Start or Stop.
	// The pulse ends long before the first clock low of the frame, so no edge is lost.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			link_rst_r <= 1'b1;
		end else begin
			link_rst_r <= link_rst_nxt;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			static_mode_r <= 1'b1;
		end else if (stop_seen) begin
			static_mode_r <= 1'b1;
		end else if (start_seen) begin
			static_mode_r <= 1'b0;
		end
	end

	// Every supply reset, first or after a drop, reloads the default code.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			volatile_wiper_setting_r <= WIPER_RESET;
		end else if (wr_event) begin
			volatile_wiper_setting_r <= lk.wr_code;
		end
	end

	// One tap per code, 128 of them.
	for (genvar t = 0; t < TAP_COUNT; t++) begin : g_tap
		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				tap_select_r[t] <= 1'b0;
			end else begin
				tap_select_r[t] <= code_is(volatile_wiper_setting_r, 7'(t));
			end
		end
	end

	// End flags lag the code by one cycle, as the tap decoder does.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			zero_scale_r <= 1'b0;
		end else begin
			zero_scale_r <= zero_hit;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			full_scale_r <= 1'b0;
		end else begin
			full_scale_r <= full_hit;
		end
	end

	// Clock pin is never pulled, so the master never waits on us.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scl_oe_r <= 1'b0;
		end else begin
			scl_oe_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scl_out_r <= 1'b0;
		end else begin
			scl_out_r <= 1'b0;
		end
	end

	// The data enable comes from the link side; this level is only ever low.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sda_out_r <= 1'b0;
		end else begin
			sda_out_r <= 1'b0;
		end
	end

	// The read value only changes after a completed write, before a new Start, or in a supply reset,
	// so it is steady whenever the link side samples it.
	assign lk.link_rst = link_rst_r;
	assign lk.rd_code  = volatile_wiper_setting_r;

	vwp_link #(
		.ADDR (ADDR)
	) u_link (
		.scl    (scl),
		.rst    (rst),
		.sda_in (sda_in),
		.lk     (lk.link)
	);


	// Outputs, each straight from a flop.
	assign scl_out     = scl_out_r;
	assign scl_oe      = scl_oe_r;
	assign sda_out     = sda_out_r;
	assign sda_oe      = lk.sda_oe;
	assign wiper_code  = volatile_wiper_setting_r;
	assign tap_select  = tap_select_r;
	assign zero_scale  = zero_scale_r;
	assign full_scale  = full_scale_r;
	assign static_mode = static_mode_r;
endmodule : vwp_top
`default_nettype wire

// ===== dv/vwp_master.sv
// Bus master model that makes the serial clock and drives the data line.
`timescale 1ns/1ns
`default_nettype none
module vwp_master (
	// Bus lines; the clock stands high outside frames.
	output logic      scl,
	output logic      sda_m,
	input  wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic start();
		sda_m = 1'b1;
		#12 scl = 1'b1;
		#12 sda_m = 1'b0;
		#120 scl = 1'b0;
	endtask : start
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			sda_m = (i > 0) ? tx[i-1] : ack_in;
			#12 scl = 1'b1;
			#24;
			if (i > 0) rx[i-1] = sda;
			else ack = sda;
			scl = 1'b0;
			#12;
		end
	endtask : xfer
	task automatic stop();
		sda_m = 1'b0;
		#12 scl = 1'b1;
		#120 sda_m = 1'b1;
		#24;
	endtask : stop
endmodule : vwp_master
`default_nettype wire

// ===== dv/vwp_props.sv
// Port checks for the volatile wiper block.
`timescale 1ns/1ns
`default_nettype none
module vwp_props
	import vwp_pkg::*;
(
	// Every port of the block, watched only.
	input wire logic                 clock,
	input wire logic                 rst,
	input wire logic                 scl,
	input wire logic                 scl_out,
	input wire logic                 scl_oe,
	input wire logic                 sda_in,
	input wire logic                 sda_out,
	input wire logic                 sda_oe,
	input wire logic [WIPER_W-1:0]   wiper_code,
	input wire logic [TAP_COUNT-1:0] tap_select,
	input wire logic                 zero_scale,
	input wire logic                 full_scale,
	input wire logic                 static_mode
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	a_scl_released: assert property (!scl_oe && !scl_out) else $error("scl driven");
	a_sda_pull_low: assert property (sda_oe |-> !sda_out) else $error("sda driven high");
	a_power_load: assert property ($fell(rst) |-> wiper_code == WIPER_RESET && static_mode)
		else $error("no default load");
	a_port_quiet: assert property ($fell(rst) |-> !sda_oe) else $error("port active in reset");
	a_static_idle: assert property (static_mode [*2] |-> !sda_oe && $stable(wiper_code))
		else $error("activity while static");
	a_zero_tap: assert property ((wiper_code == ZERO_CODE) [*2] |-> zero_scale && tap_select[0] && !full_scale)
		else $error("zero tap wrong");
	a_full_tap: assert property ((wiper_code == FULL_CODE) [*2] |-> full_scale && tap_select[127] && !zero_scale)
		else $error("full tap wrong");
	a_tap_onehot: assert property (!$past(rst) |-> tap_select == (128'h1 << $past(wiper_code)))
		else $error("tap select wrong");
	c_ack: cover property (!sda_oe ##1 sda_oe);
	c_zero: cover property (zero_scale);
	c_full: cover property (full_scale);
endmodule : vwp_props
bind vwp_top vwp_props u_props (.clock(clock), .rst(rst), .scl(scl), .scl_out(scl_out), .scl_oe(scl_oe),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .wiper_code(wiper_code), .tap_select(tap_select),
	.zero_scale(zero_scale), .full_scale(full_scale), .static_mode(static_mode));
`default_nettype wire

// ===== dv/vwp_top_tb.sv
// Self-checking bench for the volatile wiper block.
`timescale 1ns/1ns
`default_nettype none
module vwp_top_tb;
	import vwp_pkg::*;
	logic clock, rst, scl_m, sda_m, scl_out, scl_oe, sda_out, sda_oe, zero_scale, full_scale, static_mode, ack;
	logic [6:0]   wiper_code;
	logic [127:0] tap_select;
	logic [7:0]   rx;
	int           n_fail, n_checks;
	// Open-drain wires with pull-ups: released lines read high.
	wire logic    scl_w = scl_m & ~scl_oe;
	wire logic    sda_w = sda_m & ~sda_oe;
	// Written byte in the top half, expected code in the low half.
	logic [15:0]  rows [4] = '{16'h0000, 16'h7f7f, 16'hff7f, 16'h4040};
	always #10 clock = ~clock;
	vwp_top dut (.clock(clock), .rst(rst), .scl(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .wiper_code(wiper_code), .tap_select(tap_select),
		.zero_scale(zero_scale), .full_scale(full_scale), .static_mode(static_mode));
	vwp_master m (.scl(scl_m), .sda_m(sda_m), .sda(sda_w));
	task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test
	task automatic settle();
		int i;
		for (i = 0; i < 20 && static_mode !== 1'b1; i++) @(posedge clock);
		if (i == 20) begin
			n_fail++;
			finish_test();
		end
		repeat (2) @(posedge clock);
	endtask : settle
	task automatic frame(input logic [7:0] a, input logic [7:0] d, input logic ea);
		m.start();
		chk("static", 8'h00, {7'h0, static_mode});
		m.xfer(a, 1'b1, rx, ack);
		chk("addr_ack", {7'h0, ea}, {7'h0, ack});
		m.xfer(d, 1'b1, rx, ack);
		chk("data_ack", {7'h0, ea | a[0]}, {7'h0, ack});
		m.stop();
		settle();
	endtask : frame
	initial begin
		clock = 1'b0;
		rst = 1'b1;
		n_fail = 0;
		n_checks = 0;
		repeat (16) @(posedge clock);
		chk("rst_wiper", 8'h3f, {1'b0, wiper_code});
		chk("rst_sda", 8'h00, {7'h0, sda_oe});
		chk("rst_static", 8'h01, {7'h0, static_mode});
		chk("rst_tap", 8'h00, {7'h0, |tap_select});
		chk("pins", 8'h00, {5'h0, scl_oe, scl_out, sda_out});
		#2 rst = 1'b0;
		repeat (4) @(posedge clock);
		chk("tap_default", 8'h01, {7'h0, tap_select[63]});
		foreach (rows[i]) begin
			frame(8'h5e, rows[i][15:8], 1'b0);
			chk("wiper", {1'b0, rows[i][6:0]}, {1'b0, wiper_code});
			chk("zero", {7'h0, rows[i][6:0] == 7'h00}, {7'h0, zero_scale});
			chk("full", {7'h0, rows[i][6:0] == 7'h7f}, {7'h0, full_scale});
			chk("tap", 8'h01, {7'h0, tap_select[rows[i][6:0]]});
			frame(8'h5f, 8'hff, 1'b0);
			chk("read", {1'b0, rows[i][6:0]}, rx);
		end
		frame(8'h20, 8'h11, 1'b1);
		frame(8'h00, 8'h11, 1'b1);
		chk("foreign", 8'h40, {1'b0, wiper_code});
		m.start();
		m.xfer(8'h5e, 1'b1, rx, ack);
		@(posedge clock);
		#2 rst = 1'b1;
		m.xfer(8'h12, 1'b1, rx, ack);
		chk("drop_ack", 8'h01, {7'h0, ack});
		chk("drop_static", 8'h01, {7'h0, static_mode});
		m.stop();
		@(posedge clock);
		#2 rst = 1'b0;
		repeat (4) @(posedge clock);
		chk("reload", 8'h3f, {1'b0, wiper_code});
		frame(8'h5e, 8'h15, 1'b0);
		chk("after", 8'h15, {1'b0, wiper_code});
		chk("pins_end", 8'h00, {5'h0, scl_oe, scl_out, sda_out});
		finish_test();
	end
endmodule : vwp_top_tb
`default_nettype wire
